/* File: rtl/drc_pkg.sv */
// drc_pkg: constants, cause layouts and timing for the dual-die reset controller.
// assumes a single 25 MHz system clock and an always-on supply for the cause flags.
package drc_pkg;

	localparam int CLK_HZ = 25000000;
	// chip reset stretch after a source goes away
	localparam int HOLD_TIME_NS = 640;
	localparam int HOLD_CYCLES_CALC = (HOLD_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int HOLD_CYCLES = (HOLD_CYCLES_CALC < 1) ? 1 : HOLD_CYCLES_CALC;

	// digital cause bit positions
	localparam int DIG_POR_BIT = 0;
	localparam int DIG_EXT_BIT = 1;
	localparam int DIG_SW_BIT = 3;
	localparam int DIG_DETAIL_LSB = 4;
	localparam int DIG_W = 6;
	// analog cause bit positions
	localparam int ANA_POR_BIT = 0;
	localparam int ANA_EXT_BIT = 1;
	localparam int ANA_WDT_BIT = 2;
	localparam int ANA_W = 3;

	localparam logic [1:0] DETAIL_RESET = 2'h0;

	typedef struct packed {
		logic [1:0] poweron_detail_cause;
		logic sw;
		logic rsvd;
		logic ext;
		logic por;
	} drc_dig_cause_s;

	typedef struct packed {
		logic wdt;
		logic ext;
		logic por;
	} drc_ana_cause_s;

	localparam drc_dig_cause_s DIG_CAUSE_RESET = '{DETAIL_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
	localparam drc_ana_cause_s ANA_CAUSE_RESET = '{1'b0, 1'b0, 1'b0};

endpackage

/* File: rtl/drc_rst_sync.sv */
// drc_rst_sync: two-stage reset synchroniser, asynchronous assert, clocked release.
// assumes arst_n may be a combination of asynchronous reset sources.
`timescale 1ns/10ps
module drc_rst_sync (
	// clock and asynchronous reset request
	input wire logic clk,
	input wire logic arst_n,
	// synchronised reset
	output logic rst_n
);

	logic meta_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			meta_reg <= 1'b1;
			rst_n <= meta_reg;
		end
	end

endmodule

/* File: rtl/drc_top.sv */
// drc_top: combines die reset sources into the chip reset and records reset causes.
// assumes rstn is the always-on domain reset; sources other than core strobes are async.
`timescale 1ns/10ps
module drc_top #(
	parameter int HOLD_CYCLES = drc_pkg::HOLD_CYCLES
) (
	// clock and always-on reset
	input wire logic clk,
	input wire logic rstn,
	// asynchronous reset sources
	input wire logic ext_reset_n,
	input wire logic dig_por_n,
	input wire logic afe_por_n,
	input wire logic afe_wdt_reset,
	input wire logic [1:0] poweron_detail_cause,
	// core requests, system clock domain
	input wire logic system_reset_request,
	input wire logic serial_download_active,
	input wire logic selfcheck_done,
	input wire logic selfcheck_fail,
	// software write-one-to-clear strobes
	input wire logic dig_cause_clr_en,
	input wire logic [drc_pkg::DIG_W-1:0] dig_cause_clr_mask,
	input wire logic ana_cause_clr_en,
	input wire logic [drc_pkg::ANA_W-1:0] ana_cause_clr_mask,
	// chip reset and status
	output logic chip_rst_n,
	output logic boot_start,
	output logic sram_valid,
	output logic analog_selfcheck_flag,
	output drc_pkg::drc_dig_cause_s digital_reset_cause,
	output drc_pkg::drc_ana_cause_s analog_reset_cause
);

	localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
	localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	initial begin
		if (HOLD_CYCLES < 1) begin
			$error("drc_top: HOLD_CYCLES must be at least one");
		end
	end

	typedef struct packed {
		logic ext_s1;
		logic ext_s2;
		logic dpor_s1;
		logic dpor_s2;
		logic apor_s1;
		logic apor_s2;
		logic wdt_s1;
		logic wdt_s2;
		logic [1:0] det_s1;
		logic [1:0] det_s2;
		logic [CNT_W-1:0] hold_cnt;
		logic hold;
		logic chip_seen;
		logic boot_start;
		logic dl_seen;
		logic mem_lost;
		logic sram_valid;
		logic selfcheck;
		drc_pkg::drc_dig_cause_s dig;
		drc_pkg::drc_ana_cause_s ana;
	} drc_state_s;

	localparam drc_state_s STATE_RESET = '{
		ext_s1: 1'b0, ext_s2: 1'b0, dpor_s1: 1'b0, dpor_s2: 1'b0,
		apor_s1: 1'b0, apor_s2: 1'b0, wdt_s1: 1'b0, wdt_s2: 1'b0,
		det_s1: 2'h0, det_s2: 2'h0, hold_cnt: CNT_ZERO, hold: 1'b1,
		chip_seen: 1'b0, boot_start: 1'b0, dl_seen: 1'b0, mem_lost: 1'b1, sram_valid: 1'b0,
		selfcheck: 1'b0, dig: drc_pkg::DIG_CAUSE_RESET, ana: drc_pkg::ANA_CAUSE_RESET
	};

	logic aon_rst_n;
	logic chip_arst_n;
	logic chip_sync_n;
	drc_state_s st_reg;
	drc_state_s st_next;

	drc_rst_sync u_aon_sync (
		.clk(clk),
		.arst_n(rstn),
		.rst_n(aon_rst_n)
	);

	// raw sources pull the chip reset down at once; release waits for the hold count
	assign chip_arst_n = aon_rst_n & ext_reset_n & dig_por_n & afe_por_n
		& ~afe_wdt_reset & ~st_reg.hold;

	drc_rst_sync u_chip_sync (
		.clk(clk),
		.arst_n(chip_arst_n),
		.rst_n(chip_sync_n)
	);

	function automatic logic set_clr(input logic cur, input logic set, input logic clr);
		set_clr = set | (cur & ~clr);
	endfunction

	always_comb begin
		logic ev_ext;
		logic ev_dpor;
		logic ev_apor;
		logic ev_wdt;
		logic ev_sw;
		logic any_ev;
		logic [drc_pkg::DIG_W-1:0] dclr;
		logic [drc_pkg::ANA_W-1:0] aclr;
		st_next = st_reg;
		// two-stage capture of the asynchronous sources
		st_next.ext_s1 = ~ext_reset_n;
		st_next.ext_s2 = st_reg.ext_s1;
		st_next.dpor_s1 = ~dig_por_n;
		st_next.dpor_s2 = st_reg.dpor_s1;
		st_next.apor_s1 = ~afe_por_n;
		st_next.apor_s2 = st_reg.apor_s1;
		st_next.wdt_s1 = afe_wdt_reset;
		st_next.wdt_s2 = st_reg.wdt_s1;
		st_next.det_s1 = poweron_detail_cause;
		st_next.det_s2 = st_reg.det_s1;
		ev_ext = st_reg.ext_s2;
		ev_dpor = st_reg.dpor_s2;
		ev_apor = st_reg.apor_s2;
		ev_wdt = st_reg.wdt_s2;
		// core request only counts while the chip is running
		ev_sw = system_reset_request & chip_sync_n & ~st_reg.hold;
		any_ev = ev_ext | ev_dpor | ev_apor | ev_wdt | ev_sw;
		// stretch the chip reset past the last active source
		if (any_ev) begin
			st_next.hold_cnt = HOLD_LOAD;
			st_next.hold = 1'b1;
		end else if (st_reg.hold_cnt != CNT_ZERO) begin
			st_next.hold_cnt = st_reg.hold_cnt - CNT_ONE;
			st_next.hold = (st_reg.hold_cnt != CNT_ONE);
		end else begin
			st_next.hold = 1'b0;
		end
		// one pulse on each release of the chip reset starts the boot kernel
		st_next.chip_seen = chip_sync_n;
		st_next.boot_start = chip_sync_n & ~st_reg.chip_seen;
		// memory validity follows power-on and download history
		if (serial_download_active && chip_sync_n) begin
			st_next.dl_seen = 1'b1;
		end
		// a lost verdict must survive the boot that follows it
		if (ev_dpor || ev_apor || (any_ev && st_reg.dl_seen)) begin
			st_next.sram_valid = 1'b0;
			st_next.mem_lost = 1'b1;
			st_next.dl_seen = 1'b0;
		end else if (st_reg.boot_start) begin
			st_next.sram_valid = ~st_reg.mem_lost;
			st_next.mem_lost = 1'b0;
		end
		// self-check flag: cleared by every chip reset, set by failed check
		if (!chip_sync_n) begin
			st_next.selfcheck = 1'b0;
		end else if (selfcheck_done) begin
			st_next.selfcheck = selfcheck_fail;
		end
		// cause flags: write one clears, a new event in the same cycle wins
		dclr = dig_cause_clr_en ? dig_cause_clr_mask : '0;
		aclr = ana_cause_clr_en ? ana_cause_clr_mask : '0;
		st_next.dig.por = set_clr(st_reg.dig.por, ev_dpor, dclr[drc_pkg::DIG_POR_BIT]);
		st_next.dig.ext = set_clr(st_reg.dig.ext, ev_ext | ev_apor,
			dclr[drc_pkg::DIG_EXT_BIT]);
		st_next.dig.sw = set_clr(st_reg.dig.sw, ev_sw, dclr[drc_pkg::DIG_SW_BIT]);
		st_next.dig.rsvd = 1'b0;
		if (ev_dpor) begin
			st_next.dig.poweron_detail_cause = st_reg.det_s2;
		end else begin
			st_next.dig.poweron_detail_cause = st_reg.dig.poweron_detail_cause
				& ~dclr[drc_pkg::DIG_DETAIL_LSB +: 2];
		end
		st_next.ana.por = set_clr(st_reg.ana.por, ev_apor | ev_dpor,
			aclr[drc_pkg::ANA_POR_BIT]);
		st_next.ana.ext = set_clr(st_reg.ana.ext, ev_ext, aclr[drc_pkg::ANA_EXT_BIT]);
		st_next.ana.wdt = set_clr(st_reg.ana.wdt, ev_wdt, aclr[drc_pkg::ANA_WDT_BIT]);
	end

	// always-on domain: only aon_rst_n resets this state; chip resets do not
	always_ff @(posedge clk or negedge aon_rst_n) begin
		if (!aon_rst_n) begin
			st_reg <= STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// chip reset output straight from the synchroniser flop
	assign chip_rst_n = chip_sync_n;
	assign boot_start = st_reg.boot_start;
	assign sram_valid = st_reg.sram_valid;
	assign analog_selfcheck_flag = st_reg.selfcheck;
	assign digital_reset_cause = st_reg.dig;
	assign analog_reset_cause = st_reg.ana;

endmodule

/* File: verification/drc_top_assertions.sv */
// drc_top_assertions: port-level checks of chip reset and cause flags.
// assumes it is bound to drc_top; clk is the only clock, rstn its reset.
`timescale 1ns/10ps
module drc_top_assertions (
	// clock and resets
	input wire logic clk, input wire logic rstn,
	input wire logic ext_reset_n, input wire logic dig_por_n,
	input wire logic afe_por_n, input wire logic afe_wdt_reset,
	// core side
	input wire logic system_reset_request, input wire logic selfcheck_done,
	input wire logic selfcheck_fail, input wire logic dig_cause_clr_en,
	input wire logic [drc_pkg::DIG_W-1:0] dig_cause_clr_mask,
	// outputs
	input wire logic chip_rst_n, input wire logic boot_start,
	input wire logic analog_selfcheck_flag,
	input wire drc_pkg::drc_dig_cause_s digital_reset_cause,
	input wire drc_pkg::drc_ana_cause_s analog_reset_cause
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	src_reset_a: assert property (!ext_reset_n || !dig_por_n || !afe_por_n || afe_wdt_reset
		|-> !chip_rst_n) else $error("chip reset not held by a source");
	ext_cause_a: assert property (!ext_reset_n [*4] |-> ##[0:3]
		(digital_reset_cause.ext && analog_reset_cause.ext)) else $error("pin cause missing");
	wdt_cause_a: assert property (afe_wdt_reset [*4] |-> ##[0:3] analog_reset_cause.wdt)
		else $error("watchdog cause missing");
	sw_reset_a: assert property (system_reset_request && chip_rst_n |=>
		digital_reset_cause.sw ##[0:3] !chip_rst_n) else $error("software reset lost");
	boot_pulse_a: assert property ($rose(chip_rst_n) |-> ##[0:2] boot_start ##1 !boot_start)
		else $error("boot pulse wrong");
	cause_hold_a: assert property (digital_reset_cause.sw && !dig_cause_clr_en |=>
		digital_reset_cause.sw) else $error("cause flag lost");
	cause_clear_a: assert property (dig_cause_clr_en && dig_cause_clr_mask[3]
		&& !system_reset_request |=> !digital_reset_cause.sw) else $error("cause not cleared");
	fail_flag_a: assert property (selfcheck_done && selfcheck_fail && chip_rst_n
		|=> analog_selfcheck_flag) else $error("selfcheck flag not set");
	flag_drop_a: assert property (!chip_rst_n [*2] |-> !analog_selfcheck_flag)
		else $error("selfcheck flag kept in reset");
	cover property (system_reset_request && chip_rst_n);
	cover property (afe_wdt_reset [*4]);
	cover property (selfcheck_done && selfcheck_fail);
endmodule
bind drc_top drc_top_assertions u_drc_top_assertions (.clk(clk), .rstn(rstn),
	.ext_reset_n(ext_reset_n), .dig_por_n(dig_por_n), .afe_por_n(afe_por_n),
	.afe_wdt_reset(afe_wdt_reset), .system_reset_request(system_reset_request),
	.selfcheck_done(selfcheck_done), .selfcheck_fail(selfcheck_fail),
	.dig_cause_clr_en(dig_cause_clr_en), .dig_cause_clr_mask(dig_cause_clr_mask),
	.chip_rst_n(chip_rst_n), .boot_start(boot_start),
	.analog_selfcheck_flag(analog_selfcheck_flag),
	.digital_reset_cause(digital_reset_cause), .analog_reset_cause(analog_reset_cause));

/* File: verification/drc_core_model.sv */
// drc_core_model: firmware side; reset requests, self-check report, cause clears.
// assumes tasks are called by the bench just after a clock edge.
`timescale 1ns/10ps
module drc_core_model (
	input wire logic clk,
	input wire logic chip_rst_n,
	output logic system_reset_request,
	output logic selfcheck_done,
	output logic selfcheck_fail,
	output logic dig_cause_clr_en,
	output logic [drc_pkg::DIG_W-1:0] dig_cause_clr_mask,
	output logic ana_cause_clr_en,
	output logic [drc_pkg::ANA_W-1:0] ana_cause_clr_mask
);
	initial begin
		{system_reset_request, selfcheck_done, selfcheck_fail} = 3'h0;
		{dig_cause_clr_en, dig_cause_clr_mask, ana_cause_clr_en, ana_cause_clr_mask} = 11'h000;
	end
	// keyed write reduced to one request strobe, only while running
	task automatic sw_reset;
		@(posedge clk);
		system_reset_request <= chip_rst_n;
		@(posedge clk);
		system_reset_request <= 1'b0;
	endtask
	task automatic report_check(input logic fail);
		@(posedge clk);
		selfcheck_done <= 1'b1;
		selfcheck_fail <= fail;
		@(posedge clk);
		selfcheck_done <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	// write-one-to-clear of both cause sets
	task automatic clear(input logic [5:0] dm, input logic [2:0] am);
		@(posedge clk);
		{dig_cause_clr_en, dig_cause_clr_mask, ana_cause_clr_en, ana_cause_clr_mask} <= {1'b1, dm, 1'b1, am};
		@(posedge clk);
		{dig_cause_clr_en, ana_cause_clr_en} <= 2'h0;
		@(posedge clk);
		#1;
	endtask
endmodule

/* File: verification/test_drc_top.sv */
// test_drc_top: drives reset sources and firmware actions, checks cause flags.
// assumes a short hold count; core model stands for firmware.
`timescale 1ns/10ps
module test_drc_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] src = 4'h0;
	logic [1:0] detail = 2'h0;
	logic dl = 1'b0;
	logic srr, scd, scf, dce, ace, chip_rst_n, boot_start, sram_valid, flag;
	logic [5:0] dcm;
	logic [2:0] acm;
	drc_pkg::drc_dig_cause_s dig;
	drc_pkg::drc_ana_cause_s ana;
	int fail_count = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	drc_top #(.HOLD_CYCLES(2)) u_drc_top (.clk(clk), .rstn(rstn), .ext_reset_n(~src[0]),
		.dig_por_n(~src[1]), .afe_por_n(~src[2]), .afe_wdt_reset(src[3]),
		.poweron_detail_cause(detail), .system_reset_request(srr),
		.serial_download_active(dl), .selfcheck_done(scd), .selfcheck_fail(scf),
		.dig_cause_clr_en(dce), .dig_cause_clr_mask(dcm), .ana_cause_clr_en(ace),
		.ana_cause_clr_mask(acm), .chip_rst_n(chip_rst_n), .boot_start(boot_start),
		.sram_valid(sram_valid), .analog_selfcheck_flag(flag),
		.digital_reset_cause(dig), .analog_reset_cause(ana));
	drc_core_model u_drc_core_model (.clk(clk), .chip_rst_n(chip_rst_n),
		.system_reset_request(srr), .selfcheck_done(scd), .selfcheck_fail(scf),
		.dig_cause_clr_en(dce), .dig_cause_clr_mask(dcm), .ana_cause_clr_en(ace),
		.ana_cause_clr_mask(acm));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// bounded wait for reset entry, then release, then boot
	task automatic wait_run;
		int n;
		n = 0;
		while (chip_rst_n === 1'b1 && n < 8) begin
			@(posedge clk);
			n++;
		end
		while (chip_rst_n !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			fail_count++;
			close_out();
		end
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic hit(input int s, input logic [7:0] ed, input logic [7:0] ea);
		@(posedge clk);
		src[s] <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check(chip_rst_n, 8'h00);
		@(posedge clk);
		src[s] <= 1'b0;
		wait_run();
		check({2'h0, dig}, ed);
		check({5'h0, ana}, ea);
		u_drc_core_model.clear(6'h3F, 3'h7);
		check({2'h0, dig, ana}, 8'h00);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		wait_run();
		check({2'h0, dig, ana}, 8'h00);
		check(flag, 8'h00);
		@(posedge clk);
		src[0] <= 1'b1;
		repeat (4) @(posedge clk);
		src[0] <= 1'b0;
		wait_run();
		u_drc_core_model.sw_reset();
		wait_run();
		check({2'h0, dig}, 8'h0A);
		check(sram_valid, 8'h01);
		u_drc_core_model.clear(6'h3F, 3'h7);
		@(posedge clk);
		detail <= 2'h2;
		hit(1, 8'h21, 8'h01);
		hit(2, 8'h02, 8'h01);
		hit(3, 8'h00, 8'h04);
		u_drc_core_model.report_check(1'b1);
		check(flag, 8'h01);
		@(posedge clk);
		dl <= 1'b1;
		u_drc_core_model.sw_reset();
		dl <= 1'b0;
		wait_run();
		check(flag, 8'h00);
		check(sram_valid, 8'h00);
		check({2'h0, dig}, 8'h08);
		close_out();
	end
endmodule
